// File: common/dtf_defs.vh
// Constants for the debug trace FIFO readout block.
// Assumes a 32-bit APB slave; every register takes one aligned word.
`ifndef DTF_DEFS_VH
`define DTF_DEFS_VH

// Register byte offsets
`define DTF_OFF_HIGH 12'h000
`define DTF_OFF_LOW 12'h004
`define DTF_OFF_CTRL 12'h008
`define DTF_OFF_STAT 12'h00c

// Control register fields
`define DTF_CTRL_EVONLY 0
`define DTF_CTRL_ARM 1
`define DTF_CTRL_RST 2'h0

// Status register fields
`define DTF_STAT_EMPTY 0
`define DTF_STAT_FULL 1
`define DTF_STAT_ARMED 2
`define DTF_STAT_CNT_LSB 8

// FIFO shape: word width and delay-line depth
`define DTF_WORD_W 16
`define DTF_DEPTH 8

`endif

// File: src/dtf_sync2.v
// Two-stage synchroniser for a level arriving from outside mclk.
// Assumes the input is a slow level; pulses shorter than a cycle may be lost.
`timescale 1ns/1ps
`default_nettype none
module dtf_sync2 (
    input wire mclk,
    input wire rst_n,
    input wire din,
    output wire dout
);
    reg meta_ff;
    reg sync_ff;

    // First stage only feeds the second stage
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule
`default_nettype wire

// File: src/dtf_fifo.v
// Flip-flop FIFO with valid/ready on both sides and an occupancy count.
// Assumes one clock; push and pop in one cycle are allowed even when full.
`timescale 1ns/1ps
`default_nettype none
module dtf_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire mclk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0] count
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] cnt_ff;
    wire do_push;
    wire do_pop;
    integer i;

    // A full FIFO still accepts a word when one leaves in the same cycle
    assign out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign in_ready = (cnt_ff != DEPTH[AW:0]) || out_ready;
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ptr_ff];
    assign count = cnt_ff;

    // Storage, pointers and count
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_ff[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (do_push) begin
                mem_ff[wr_ptr_ff] <= in_data;
                wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    wr_ptr_ff + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    rd_ptr_ff + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: src/dtf_trace_readout.v
// Debug trace FIFO readout: APB slave with high/low byte read ports.
// Assumes trace capture and opcode address come from logic on mclk;
// the external arm pin is asynchronous and is synchronised here.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dtf_defs.vh"

// Behaviour
// R1: Reading the high-byte register returns bits 15:8 of the head word.
// R2: Reading the low-byte register returns bits 7:0 of the head word.
// R3: Writes to both byte registers change neither contents nor position.
// R4: Event-only capture stores low byte only; high byte reads zero.
// R5: High-byte reads never move the FIFO.
// R6: Low-byte reads advance the FIFO, except while armed.
// R7: Host reads high byte before low byte for 16-bit entries.
// R8: Host may read low byte repeatedly for 8-bit entries.
// R9: While armed, low-byte reads do not advance the FIFO.
// R10: Host should not read FIFO data while still armed.
// R11: Unarmed low-byte reads store latest opcode address in last location.
// R12: Unarmed, the FIFO is an eight-deep delay line of read samples.
// R13: Host discards eight reads to prime profiling, then uses delayed samples.
module dtf_trace_readout #(
    parameter WIDTH = `DTF_WORD_W,
    parameter DEPTH = `DTF_DEPTH,
    parameter AW = 3
) (
    input wire mclk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire trace_valid,
    input wire [WIDTH-1:0] trace_data,
    output wire trace_ready,
    input wire [WIDTH-1:0] opcode_addr,
    input wire arm_pin,
    output wire trace_arm_flag
);
    reg [31:0] prdata_ff;
    reg pready_ff;
    reg pslverr_ff;
    reg arm_ff;
    reg evonly_ff;
    reg [AW:0] cap_left_ff;
    reg pin_prev_ff;
    reg trace_ready_ff;
    reg [31:0] nxt_prdata;
    reg nxt_pslverr;
    reg nxt_arm;
    reg [AW:0] nxt_cap_left;
    wire arm_pin_sync;
    wire xfer_done;
    wire rd_low;
    wire wr_ctrl;
    wire cap_push;
    wire prof_push;
    wire fifo_push;
    wire fifo_pop;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [WIDTH-1:0] fifo_head;
    wire [WIDTH-1:0] fifo_in_data;
    wire [AW:0] fifo_cnt;
    wire [AW:0] cnt_next;
    wire fifo_full;

    // Address match helper, shared by read mux and side-effect decode
    function hit;
        input [11:0] addr;
        input [11:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // External arm request crosses into mclk first
    dtf_sync2 u_arm_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(arm_pin),
        .dout(arm_pin_sync)
    );

    // Transfer completes at the edge where the master samples pready
    assign xfer_done = psel && penable && pready_ff;
    assign rd_low = xfer_done && !pwrite && hit(paddr, `DTF_OFF_LOW);
    assign wr_ctrl = xfer_done && pwrite && hit(paddr, `DTF_OFF_CTRL);
    assign fifo_full = (fifo_cnt == DEPTH[AW:0]);

    // Capture path: trigger logic fills only while armed, stalled by trace_ready
    assign cap_push = arm_ff && trace_valid && trace_ready_ff;
    // Unarmed low reads sample the opcode address into the tail [R11]
    assign prof_push = rd_low && !arm_ff;
    assign fifo_push = cap_push || prof_push;
    // Event-only capture keeps the upper half clear [R4]
    assign fifo_in_data = prof_push ? opcode_addr :
        (evonly_ff ? {{(WIDTH-8){1'b0}}, trace_data[7:0]} : trace_data);

    // Low reads pop unless armed [R6] [R9]; high reads never pop [R5].
    // While profiling, no pop until eight samples are held, so the
    // ninth read returns the first sample [R12]; captured words drain
    // first, counted so that a partial capture cannot stall the refill.
    assign fifo_pop = rd_low && !arm_ff && fifo_out_valid &&
        (fifo_full || cap_left_ff != {(AW+1){1'b0}});

    assign cnt_next = fifo_cnt + {{AW{1'b0}}, fifo_push} - {{AW{1'b0}}, fifo_pop};

    dtf_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_head),
        .count(fifo_cnt)
    );

    // Read mux and error answer; writes to byte ports are dropped [R3]
    always @* begin
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        if (hit(paddr, `DTF_OFF_HIGH)) begin
            if (!pwrite) begin
                nxt_prdata[7:0] = fifo_head[15:8]; // [R1]
            end
        end else if (hit(paddr, `DTF_OFF_LOW)) begin
            if (!pwrite) begin
                nxt_prdata[7:0] = fifo_head[7:0]; // [R2]
            end
        end else if (hit(paddr, `DTF_OFF_CTRL)) begin
            nxt_prdata[`DTF_CTRL_EVONLY] = evonly_ff;
            nxt_prdata[`DTF_CTRL_ARM] = arm_ff;
        end else if (hit(paddr, `DTF_OFF_STAT)) begin
            nxt_prdata[`DTF_STAT_EMPTY] = !fifo_out_valid;
            nxt_prdata[`DTF_STAT_FULL] = fifo_full;
            nxt_prdata[`DTF_STAT_ARMED] = arm_ff;
            nxt_prdata[`DTF_STAT_CNT_LSB+AW:`DTF_STAT_CNT_LSB] = fifo_cnt;
        end else begin
            nxt_pslverr = 1'b1;
        end
        if (pwrite) begin
            nxt_prdata = 32'h0000_0000;
        end
    end

    // Arm flag: software or pin sets it, filling clears it.
    // A set in the same cycle as the fill wins so an arm is never lost.
    always @* begin
        nxt_arm = arm_ff;
        if (arm_ff && cap_push && cnt_next == DEPTH[AW:0]) begin
            nxt_arm = 1'b0;
        end
        if (wr_ctrl) begin
            nxt_arm = pwdata[`DTF_CTRL_ARM];
        end
        if (arm_pin_sync && !pin_prev_ff) begin
            nxt_arm = 1'b1;
        end
    end

    // Captured words still queued; each unarmed pop retires one.
    // Capture needs arm and pop needs no arm, so both never coincide.
    always @* begin
        nxt_cap_left = cap_left_ff;
        if (cap_push) begin
            nxt_cap_left = cap_left_ff + 1'b1;
        end else if (fifo_pop && cap_left_ff != {(AW+1){1'b0}}) begin
            nxt_cap_left = cap_left_ff - 1'b1;
        end
    end

    // Bus answer: one wait state, pready rises the cycle after penable
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (psel && penable && !pready_ff) begin
            prdata_ff <= nxt_prdata;
            pready_ff <= 1'b1;
            pslverr_ff <= nxt_pslverr;
        end else begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // Control state and capture back-pressure
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            arm_ff <= 1'b0;
            evonly_ff <= 1'b0;
            cap_left_ff <= {(AW+1){1'b0}};
            pin_prev_ff <= 1'b0;
            trace_ready_ff <= 1'b0;
        end else begin
            arm_ff <= nxt_arm;
            cap_left_ff <= nxt_cap_left;
            pin_prev_ff <= arm_pin_sync;
            if (wr_ctrl) begin
                evonly_ff <= pwdata[`DTF_CTRL_EVONLY];
            end
            // Ready only while armed with room left after this cycle
            trace_ready_ff <= nxt_arm && (cnt_next < DEPTH[AW:0]) && fifo_in_ready;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign trace_ready = trace_ready_ff;
    assign trace_arm_flag = arm_ff;
endmodule
`default_nettype wire

// File: bench/dtf_readout_monitor.sv
// Checker for the trace readout block, bound to its top ports.
// Assumes the single mclk domain and the active-low reset rst_n.
`timescale 1ns/1ps
`default_nettype none
module dtf_readout_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic trace_valid,
    input wire logic trace_ready,
    input wire logic trace_arm_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Answer timing: one wait state, one-cycle answer, quiet bus otherwise
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    wait_state_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("answer not after one wait state");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    // Byte ports carry eight bits; writes there are quietly accepted
    high_upper_a: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 0)
        else $error("high byte port too wide");
    low_upper_a: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[31:8] == 0)
        else $error("low byte port too wide");
    byte_ok_a: assert property (pready && paddr < 12'h008 |-> !pslverr)
        else $error("byte port access refused");
    unmapped_err_a: assert property (pready && paddr >= 12'h010 |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    // Capture only while armed, so a disarmed FIFO never takes trace words
    take_armed_a: assert property (trace_ready |-> trace_arm_flag)
        else $error("capture ready while unarmed");
    cover property (pready && paddr == 12'h004);
    cover property (trace_valid && trace_ready);
    cover property ($fell(trace_arm_flag));
endmodule
bind dtf_trace_readout dtf_readout_monitor i_mon (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trace_valid(trace_valid), .trace_ready(trace_ready),
    .trace_arm_flag(trace_arm_flag));
`default_nettype wire

// File: bench/dtf_host_model.sv
// Host debug software model: APB master issuing one transfer at a time.
// Assumes each call starts just after a rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module dtf_host_model (
    input wire logic mclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // Request held until pready is seen; an idle cycle avoids double drives
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!pready && n < 50);
        if (!pready)
            test_debug_trace_fifo_readout.timed_out();
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// File: bench/test_debug_trace_fifo_readout.sv
// Testbench: armed capture, drain, profiling delay line, bus refusals.
// Assumes the host model drives APB and the bound checker watches ports.
`timescale 1ns/1ps
`default_nettype none
`include "dtf_defs.vh"
module test_debug_trace_fifo_readout;
    logic mclk, rst_n, trace_valid, trace_ready, trace_arm_flag, arm_pin;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] trace_data, opcode_addr;
    logic [15:0] q[$];
    int failures, checked;
    dtf_trace_readout i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trace_valid(trace_valid), .trace_data(trace_data),
        .trace_ready(trace_ready), .opcode_addr(opcode_addr), .arm_pin(arm_pin),
        .trace_arm_flag(trace_arm_flag));
    dtf_host_model i_host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task timed_out;
        failures++;
        $display("mismatch at %0t: wait ran out", $time);
        wrap_up();
    endtask
    // Model queue empties with the FIFO
    task do_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        q.delete();
    endtask
    // One capture word, offered until the block takes it
    task put(input logic [7:0] k);
        int n;
        trace_valid <= 1'b1;
        trace_data <= {8'h5a, k};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!trace_ready && n < 20);
        if (!trace_ready)
            timed_out();
        trace_valid <= 1'b0;
        @(posedge mclk);
    endtask
    // One sample: high half first, since the low read moves the FIFO on
    task sample;
        logic [31:0] h, h2, l;
        i_host.xfer(1'b0, `DTF_OFF_HIGH, 32'h0000_0000, h);
        i_host.xfer(1'b0, `DTF_OFF_HIGH, 32'h0000_0000, h2);
        i_host.xfer(1'b0, `DTF_OFF_LOW, 32'h0000_0000, l);
        chk(h2, h);
        if (q.size() == 8)
            chk({h[23:0], l[7:0]}, {16'h0000, q[0]});
        q.push_back(opcode_addr);
        if (q.size() > 8)
            void'(q.pop_front());
        opcode_addr <= opcode_addr + 16'h0123;
    endtask
    task t_capture;
        int n;
        i_host.xfer(1'b1, `DTF_OFF_CTRL, 32'h0000_0003, r);
        i_host.xfer(1'b0, `DTF_OFF_CTRL, 32'h0000_0000, r);
        chk(r, 32'h0000_0003);
        for (n = 0; n < 8; n++) begin
            put(n[7:0]);
            if (n == 2)
                i_host.xfer(1'b0, `DTF_OFF_LOW, 32'h0000_0000, r);
        end
        chk({31'h0000_0000, trace_arm_flag}, 32'h0000_0000);
        // Full, not armed, eight words held; data reads wait for this
        i_host.xfer(1'b0, `DTF_OFF_STAT, 32'h0000_0000, r);
        chk(r, 32'h0000_0802);
        i_host.xfer(1'b1, `DTF_OFF_CTRL, 32'h0000_0000, r);
        for (n = 0; n < 8; n++)
            q.push_back({8'h00, n[7:0]});
        for (n = 0; n < 4; n++)
            sample();
        // Event-only bytes fetched by low reads alone
        for (n = 0; n < 4; n++) begin
            i_host.xfer(1'b0, `DTF_OFF_LOW, 32'h0000_0000, r);
            chk(r, {24'h00_0000, q[0][7:0]});
            void'(q.pop_front());
            q.push_back(opcode_addr);
            opcode_addr <= opcode_addr + 16'h0123;
        end
        $display("capture and drain done");
    endtask
    // Rising arm pin sets the flag; a control write clears it again
    task t_pin_arm;
        int n;
        arm_pin <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!trace_arm_flag && n < 10);
        chk({31'h0000_0000, trace_arm_flag}, 32'h0000_0001);
        i_host.xfer(1'b1, `DTF_OFF_CTRL, 32'h0000_0000, r);
        arm_pin <= 1'b0;
        chk({31'h0000_0000, trace_arm_flag}, 32'h0000_0000);
        $display("pin arm done");
    endtask
    task t_profile;
        int n;
        for (n = 0; n < 8; n++)
            sample();
        i_host.xfer(1'b1, `DTF_OFF_HIGH, 32'hffff_ffff, r);
        i_host.xfer(1'b1, `DTF_OFF_LOW, 32'hffff_ffff, r);
        sample();
        i_host.xfer(1'b0, 12'h010, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        do_reset();
        for (n = 0; n < 9; n++)
            sample();
        $display("profiling done");
    endtask
    initial begin
        rst_n = 1'b0;
        trace_valid = 1'b0;
        arm_pin = 1'b0;
        trace_data = 16'h0000;
        opcode_addr = 16'h1234;
        failures = 0;
        checked = 0;
        do_reset();
        t_capture();
        t_pin_arm();
        t_profile();
        wrap_up();
    end
endmodule
`default_nettype wire
